/* File: hw/smbd_buf2.v */
// two-entry valid/ready buffer for received bytes
`timescale 1ns/10ps
`default_nettype none
module smbd_buf2
#(
  parameter WIDTH = 8
)
(
  input  wire             core_clk_i,
  input  wire             arst_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:1];
  reg             wr_ptr;
  reg             rd_ptr;
  reg [1:0]       count;
  wire            do_wr;
  wire            do_rd;
  assign in_ready_o  = (count != 2'd2);
  assign out_valid_o = (count != 2'd0);
  assign out_data_o  = mem[rd_ptr];
  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_valid_o && out_ready_i;
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
      mem[0] <= {WIDTH{1'b0}};
      mem[1] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= ~wr_ptr;
      end
      if (do_rd)
        rd_ptr <= ~rd_ptr;
      if (do_wr && !do_rd)
        count <= count + 2'd1;
      else if (do_rd && !do_wr)
        count <= count - 2'd1;
    end
  end
endmodule
`default_nettype wire

/* File: hw/smbd_defs.vh */
// constants for the smbus data shifter
`ifndef SMBD_DEFS_VH
`define SMBD_DEFS_VH
`define SMBD_ADDR_DATA      8'hc2
`define SMBD_ADDR_CTRL      8'hc0
`define SMBD_DATA_RST       8'h00
`define SMBD_CTRL_EN_BIT    0
`define SMBD_CTRL_STA_BIT   1
`define SMBD_CTRL_STO_BIT   2
`define SMBD_CTRL_ACK_BIT   3
`define SMBD_CTRL_SI_BIT    4
`define SMBD_CTRL_MST_BIT   5
`define SMBD_CTRL_TX_BIT    6
`define SMBD_CTRL_ARB_BIT   7
`define SMBD_CLK_PERIOD_NS  4
`define SMBD_SCL_HALF_NS    2500
`define SMBD_SCL_HALF_CYC   ((`SMBD_SCL_HALF_NS + `SMBD_CLK_PERIOD_NS - 1) / `SMBD_CLK_PERIOD_NS)
`endif

/* File: hw/smbd_shifter.v */
// smbus data register, shift path and byte sequencer
`timescale 1ns/10ps
`default_nettype none
`include "smbd_defs.vh"
module smbd_shifter
#(
  parameter SCL_HALF = `SMBD_SCL_HALF_CYC
)
(
  input  wire       core_clk_i,
  input  wire       arst_n_i,
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire       sfr_rd_i,
  input  wire [7:0] sfr_wdata_i,
  output reg  [7:0] sfr_rdata_o,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  input  wire       scl_i,
  output reg        scl_o,
  output reg        scl_oe_o,
  output reg        rx_valid_o,
  input  wire       rx_ready_i,
  output reg  [7:0] rx_data_o
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_BIT   = 3'd2;
  localparam ST_ACK   = 3'd3;
  localparam ST_DONE  = 3'd4;
  localparam ST_STOP  = 3'd5;

  reg  [7:0]  shift;
  reg  [2:0]  state;
  reg  [3:0]  bit_cnt;
  reg  [15:0] div_cnt;
  reg         phase;
  reg         enable;
  reg         start_req;
  reg         stop_req;
  reg         ack_out;
  reg         ack_seen;
  reg         byte_done;
  reg         master;
  reg         tx_mode;
  reg         arb_lost;
  reg         scl_d;
  reg         sda_d;
  reg         buf_push;
  wire        sda_s;
  wire        scl_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire        tick;
  wire        buf_ready;
  wire        buf_valid;
  wire [7:0]  buf_data;
  wire        wr_data;
  wire        wr_ctrl;
  wire        buf_take;

  smbd_sync u_sync_sda
  (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (sda_i),
    .sync_o     (sda_s)
  );
  smbd_sync u_sync_scl
  (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (scl_i),
    .sync_o     (scl_s)
  );
  smbd_buf2 #(.WIDTH(8)) u_rx_buf
  (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_ready),
    .in_data_i   (shift),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_take),
    .out_data_o  (buf_data)
  );

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
  assign tick      = (div_cnt == 16'd0);
  // data register writes are only honoured while byte-done is set, disabled or idle
  assign wr_data   = sfr_wr_i && (sfr_addr_i == `SMBD_ADDR_DATA)
                     && (byte_done || !enable || state == ST_IDLE);
  assign wr_ctrl   = sfr_wr_i && (sfr_addr_i == `SMBD_ADDR_CTRL);
  assign buf_take  = !rx_valid_o || rx_ready_i;

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      shift       <= `SMBD_DATA_RST;
      state       <= ST_IDLE;
      bit_cnt     <= 4'd0;
      div_cnt     <= 16'd0;
      phase       <= 1'b0;
      enable      <= 1'b0;
      start_req   <= 1'b0;
      stop_req    <= 1'b0;
      ack_out     <= 1'b0;
      ack_seen    <= 1'b0;
      byte_done   <= 1'b0;
      master      <= 1'b0;
      tx_mode     <= 1'b0;
      arb_lost    <= 1'b0;
      scl_d       <= 1'b1;
      sda_d       <= 1'b1;
      buf_push    <= 1'b0;
      sda_o       <= 1'b0;
      sda_oe_o    <= 1'b0;
      scl_o       <= 1'b0;
      scl_oe_o    <= 1'b0;
      sfr_rdata_o <= 8'h00;
      rx_valid_o  <= 1'b0;
      rx_data_o   <= 8'h00;
    end
    else
    begin
      scl_d      <= scl_s;
      sda_d      <= sda_s;
      buf_push   <= 1'b0;
      if (buf_take)
      begin
        rx_valid_o <= buf_valid;
        rx_data_o  <= buf_data;
      end
      div_cnt    <= tick ? SCL_HALF[15:0] - 16'd1 : div_cnt - 16'd1;
      if (wr_data)
        shift <= sfr_wdata_i;
      if (wr_ctrl)
      begin
        enable    <= sfr_wdata_i[`SMBD_CTRL_EN_BIT];
        start_req <= sfr_wdata_i[`SMBD_CTRL_STA_BIT];
        stop_req  <= sfr_wdata_i[`SMBD_CTRL_STO_BIT];
        ack_out   <= sfr_wdata_i[`SMBD_CTRL_ACK_BIT];
        tx_mode   <= sfr_wdata_i[`SMBD_CTRL_TX_BIT];
        // clearing byte-done releases the sequencer
        if (!sfr_wdata_i[`SMBD_CTRL_SI_BIT])
          byte_done <= 1'b0;
        if (!sfr_wdata_i[`SMBD_CTRL_ARB_BIT])
          arb_lost <= 1'b0;
      end
      if (sfr_rd_i)
      begin
        if (sfr_addr_i == `SMBD_ADDR_DATA)
          sfr_rdata_o <= shift;
        else if (sfr_addr_i == `SMBD_ADDR_CTRL)
          sfr_rdata_o <= {arb_lost, tx_mode, master, byte_done,
                          ack_seen, stop_req, start_req, enable};
        else
          sfr_rdata_o <= 8'h00;
      end
      if (!enable)
      begin
        state    <= ST_IDLE;
        master   <= 1'b0;
        sda_oe_o <= 1'b0;
        scl_oe_o <= 1'b0;
      end
      else if (stop_det && state != ST_STOP)
      begin
        state    <= ST_IDLE;
        master   <= 1'b0;
        sda_oe_o <= 1'b0;
        scl_oe_o <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (start_req && !byte_done && tick && scl_s && sda_s)
            begin
              sda_oe_o <= 1'b1;
              master   <= 1'b1;
              state    <= ST_START;
            end
            else if (start_det)
            begin
              tx_mode <= 1'b0;
              bit_cnt <= 4'd0;
              state   <= ST_BIT;
            end
          end
          ST_START:
          begin
            if (tick)
            begin
              scl_oe_o  <= 1'b1;
              start_req <= 1'b0;
              tx_mode   <= 1'b1;
              bit_cnt   <= 4'd0;
              phase     <= 1'b0;
              state     <= ST_BIT;
            end
          end
          ST_BIT:
          begin
            // release clock; data was set up while it was low
            if (master && tick && !phase)
            begin
              scl_oe_o <= 1'b0;
              phase    <= 1'b1;
            end
            else if (master && tick && phase)
            begin
              scl_oe_o <= 1'b1;
              phase    <= 1'b0;
            end
            // data moves only after the clock is seen low, msb first
            if (scl_fall)
              sda_oe_o <= tx_mode && !shift[7];
            if (scl_rise)
            begin
              // bus level enters lsb while msb leaves
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'd1;
              if (master && tx_mode && shift[7] && !sda_s)
              begin
                arb_lost <= 1'b1;
                master   <= 1'b0;
                tx_mode  <= 1'b0;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
              end
              if (bit_cnt == 4'd7)
              begin
                state <= ST_ACK;
                if (!tx_mode)
                begin
                  byte_done <= 1'b1;
                  buf_push  <= buf_ready;
                end
              end
            end
          end
          ST_ACK:
          begin
            // receiver waits for software before acking
            if (!tx_mode && byte_done)
              sda_oe_o <= 1'b0;
            else
            begin
              if (scl_fall)
                sda_oe_o <= !tx_mode && ack_out;
              if (master && tick && !phase)
              begin
                scl_oe_o <= 1'b0;
                phase    <= 1'b1;
              end
              else if (master && tick && phase)
              begin
                scl_oe_o <= 1'b1;
                phase    <= 1'b0;
              end
            end
            if (scl_rise && !(byte_done && !tx_mode))
            begin
              ack_seen <= !sda_s;
              if (tx_mode)
                byte_done <= 1'b1;
              state <= ST_DONE;
            end
          end
          ST_DONE:
          begin
            // hold the bus until software clears byte-done
            if (!byte_done)
            begin
              bit_cnt <= 4'd0;
              if (master && stop_req)
                state <= ST_STOP;
              else
                state <= ST_BIT;
            end
          end
          ST_STOP:
          begin
            // clock low, data low, clock released, then data released
            if (tick)
            begin
              bit_cnt <= bit_cnt + 4'd1;
              if (bit_cnt == 4'd0)
                scl_oe_o <= 1'b1;
              else if (bit_cnt == 4'd1)
                sda_oe_o <= 1'b1;
              else if (bit_cnt == 4'd2)
                scl_oe_o <= 1'b0;
              else
              begin
                sda_oe_o <= 1'b0;
                stop_req <= 1'b0;
                master   <= 1'b0;
                state    <= ST_IDLE;
              end
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/smbd_sync.v */
// two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
`default_nettype none
module smbd_sync
(
  input  wire core_clk_i,
  input  wire arst_n_i,
  input  wire pin_i,
  output reg  sync_o
);
  reg meta;
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta   <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta   <= pin_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: tb/smbd_shifter_properties.sv */
// port assertions for the smbus data shifter
`timescale 1ns/10ps
`default_nettype none
module smbd_shifter_properties
#(
  parameter SCL_HALF = 10
)
(
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe_o,
  input wire logic       rx_valid_o,
  input wire logic       rx_ready_i,
  input wire logic [7:0] rx_data_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence rx_stall;
    (rx_valid_o && !rx_ready_i) [*2];
  endsequence
  sequence scl_pull;
    $rose(scl_oe_o);
  endsequence
  sequence scl_free;
    $fell(scl_oe_o);
  endsequence
  rdata_hold_a: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved without a read");
  reset_quiet_a: assert property (disable iff (1'b0)
    !arst_n_i |-> !sda_oe_o && !scl_oe_o && !rx_valid_o && sfr_rdata_o == 8'h00)
    else $error("outputs active in reset");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o)
    else $error("buffered byte lost while stalled");
  rx_data_a: assert property (rx_stall |=> $stable(rx_data_o))
    else $error("buffered byte changed while stalled");
  scl_low_a: assert property (scl_pull |-> scl_oe_o [*4])
    else $error("clock low phase too short");
  scl_high_a: assert property (scl_free |=> !scl_oe_o [*4])
    else $error("clock high phase too short");
  sda_setup_a: assert property ($fell(scl_oe_o) |-> $stable(sda_oe_o))
    else $error("data pin moved as clock released");
  sda_hold_a: assert property ($rose(scl_oe_o) |-> $stable(sda_oe_o))
    else $error("data pin moved as clock pulled low");
  sda_level_a: assert property (sda_o == 1'b0)
    else $error("data pin drives high");
  scl_level_a: assert property (scl_o == 1'b0)
    else $error("clock pin drives high");
endmodule
`default_nettype wire

/* File: tb/smbd_shifter_tb_top.sv */
// testbench for the smbus data shifter
`timescale 1ns/10ps
`default_nettype none
`include "smbd_defs.vh"
module smbd_shifter_tb_top;
  localparam SCL_HALF = 10;
  logic        core_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        rx_ready = 1'b0;
  logic        rx_en = 1'b1;
  logic [31:0] seed = 32'hca303128;
  logic [31:0] rs = 32'hca303128;
  logic [7:0]  tx, got, acks;
  integer      err_count = 0;
  integer      total_checks = 0;
  integer      i, n;
  wire  [7:0]  rdata, rx_data, s_byte, s_acks;
  wire         sda_o, sda_oe, scl_o, scl_oe, rx_valid, ack_oe;
  wire         sda = ~((sda_oe & ~sda_o) | ack_oe);
  wire         scl = ~(scl_oe & ~scl_o);
  always #2 core_clk_i = ~core_clk_i;
  smbd_shifter #(.SCL_HALF(SCL_HALF)) DUT (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data));
  smbd_slave_model u_slave (.scl_i(scl), .sda_i(sda), .ack_oe_o(ack_oe),
    .byte_o(s_byte), .acks_o(s_acks));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(negedge core_clk_i)
  begin
    rs <= lfsr(rs);
    rx_ready <= rs[3] && rx_en;
  end
  task complete_run;
  begin
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [7:0] g, input [7:0] e);
  begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task sfr_wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge core_clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge core_clk_i);
    wr = 1'b0;
  end
  endtask
  task sfr_rd(input [7:0] a, output [7:0] d);
  begin
    @(negedge core_clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge core_clk_i);
    rd = 1'b0;
    @(negedge core_clk_i);
    d = rdata;
  end
  endtask
  task wait_si;
  begin
    got = 8'h00;
    for (n = 0; n < 400 && got[`SMBD_CTRL_SI_BIT] !== 1'b1; n = n + 1)
      sfr_rd(`SMBD_ADDR_CTRL, got);
    if (got[`SMBD_CTRL_SI_BIT] !== 1'b1)
    begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    arst_n_i = 1'b1;
    sfr_rd(`SMBD_ADDR_DATA, got);
    chk(got, `SMBD_DATA_RST);
    seed = lfsr(seed);
    sfr_wr(`SMBD_ADDR_DATA, seed[7:0]);
    sfr_rd(`SMBD_ADDR_DATA, got);
    chk(got, seed[7:0]);
    $display("test registers done");
    for (i = 0; i < 4; i = i + 1)
    begin
      seed = lfsr(seed);
      tx = (i == 1) ? 8'hff : (i == 2) ? 8'h00 : seed[7:0];
      sfr_wr(`SMBD_ADDR_DATA, tx);
      sfr_wr(`SMBD_ADDR_CTRL, (i == 0) ? 8'h43 : 8'h41);
      repeat (60) @(negedge core_clk_i);
      // write while shifting must be ignored
      sfr_wr(`SMBD_ADDR_DATA, ~tx);
      wait_si;
      chk({7'h00, got[`SMBD_CTRL_MST_BIT]}, 8'h01);
      acks = s_acks;
      chk(acks, i[7:0] + 8'h01);
      chk(s_byte, tx);
      sfr_rd(`SMBD_ADDR_DATA, got);
      chk(got, tx);
      repeat (40) @(negedge core_clk_i);
      chk(s_acks, acks);
      sfr_rd(`SMBD_ADDR_DATA, got);
      chk(got, tx);
      $display("test byte %0d done", i);
    end
    // master receive of an idle bus, consumer stalled at first
    rx_en = 1'b0;
    acks = s_acks;
    sfr_wr(`SMBD_ADDR_CTRL, 8'h01);
    wait_si;
    chk(s_acks, acks);
    sfr_rd(`SMBD_ADDR_DATA, got);
    chk(got, 8'hff);
    chk({7'h00, rx_valid}, 8'h01);
    chk(rx_data, 8'hff);
    rx_en = 1'b1;
    for (n = 0; n < 50 && rx_valid !== 1'b0; n = n + 1)
      @(negedge core_clk_i);
    chk({7'h00, rx_valid}, 8'h00);
    $display("test receive done");
    sfr_wr(`SMBD_ADDR_CTRL, 8'h05);
    repeat (150) @(negedge core_clk_i);
    sfr_rd(`SMBD_ADDR_CTRL, got);
    chk({7'h00, got[`SMBD_CTRL_MST_BIT]}, 8'h00);
    chk({6'h00, scl, sda}, 8'h03);
    chk(s_acks, acks + 8'h01);
    $display("test stop done");
    complete_run;
  end
endmodule
bind smbd_shifter smbd_shifter_properties #(.SCL_HALF(SCL_HALF)) u_props (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .rx_valid_o(rx_valid_o),
  .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o));
`default_nettype wire

/* File: tb/smbd_slave_model.sv */
// smbus slave that acks every byte
`timescale 1ns/10ps
`default_nettype none
module smbd_slave_model
(
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       ack_oe_o,
  output var  logic [7:0] byte_o,
  output var  logic [7:0] acks_o
);
  logic [7:0] shift;
  logic [3:0] bit_n;
  initial
  begin
    ack_oe_o = 1'b0;
    byte_o = 8'h00;
    acks_o = 8'h00;
    shift = 8'h00;
    bit_n = 4'h0;
  end
  // start condition restarts framing
  always @(negedge sda_i)
    if (scl_i)
      bit_n = 4'h0;
  always @(posedge scl_i)
  begin
    if (bit_n < 4'h8)
      shift = {shift[6:0], sda_i};
    else
    begin
      byte_o = shift;
      acks_o = acks_o + 8'h01;
    end
    bit_n = bit_n + 4'h1;
  end
  always @(negedge scl_i)
  begin
    ack_oe_o = (bit_n == 4'h8);
    if (bit_n == 4'h9)
      bit_n = 4'h0;
  end
endmodule
`default_nettype wire
